// ===== logic/page_flash_host.sv
// Host controller driving a page flash through its strobe and I/O pins
//
// Contract
// R1 - Device keeps program/erase blocked while write-guard is low.
// R2 - Device holds ready/busy low during program, erase or page read.
// R3 - Ready/busy is open drain and always reports, even when deselected.
// R4 - With auto-read strapped, first page streams out without command or address.
// R5 - Address: column in cycles one and two, row in three and four, unused low.
// R6 - Host sends two column cycles, then two row cycles.
// R7 - Device ignores surplus address cycles.
// R8 - Block erase carries only the two row cycles.
// R9 - Read and program send all four address cycles after first command.
// R10 - Command, address, write data latched on write strobe rise, chip select low.
// R11 - Each page has spare columns past the main area.
// R12 - Array is 65536 pages selected by row address.
// R13 - Program and read whole pages, erase whole 64-page blocks only.
// R14 - Data and cache registers chained between I/O and array.
// R15 - Cache program takes new data while the previous page programs.
// R16 - Copy-back: read with 00h/35h, program with 85h/10h.
// R17 - Reset, status and identify are single command cycles.
// R18 - Program is 80h..10h, erase is 60h..D0h, addresses between.
// R19 - Page read is 00h, four address cycles, then 30h.
// R20 - Random input 85h and output 05h/E0h move column within page.
// R21 - Device takes only reset and status while busy.
// R22 - Host never issues undefined command codes.
// R23 - Word-wide part: command and address on low eight lines, upper low.
// R24 - Command latch high loads command register on write strobe rise.
// R25 - Address latch high loads address registers on write strobe rise.
// R26 - Each read strobe fall drives next word and advances column.
// R27 - Host waits for ready before commands other than reset and status.
`include "flash_host_params.svh"

module page_flash_host #(
  parameter bit WIDE = 1'b0,
  parameter int LEN_W = 12,
  localparam int IO_W = WIDE ? 16 : 8
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic cmd_valid_i,
  input wire flash_host_pkg::flash_op_t cmd_op_i,
  input wire logic [`COL_W-1:0] col_addr_i,
  input wire logic [`ROW_W-1:0] row_addr_i,
  input wire logic [LEN_W-1:0] len_i,
  input wire logic wr_valid_i,
  input wire logic [IO_W-1:0] wr_data_i,
  input wire logic wp_release_i,
  input wire logic rb_i,
  input wire logic [IO_W-1:0] io_i,
  output logic cmd_busy_o,
  output logic done_o,
  output logic wr_ready_o,
  output logic rd_valid_o,
  output logic [IO_W-1:0] rd_data_o,
  output logic ce_n_o,
  output logic cle_o,
  output logic ale_o,
  output logic we_n_o,
  output logic read_strobe_n_o,
  output logic wp_n_o,
  output logic [IO_W-1:0] io_o,
  output logic io_oe_o
);

  // Least times round up to whole cycles
  localparam int WLOW_I = (`T_WP_NS * `CLK_MHZ + 999) / 1000;
  localparam int WHIGH_I = (`T_WH_NS * `CLK_MHZ + 999) / 1000;
  localparam int RP_I = (`T_RP_NS * `CLK_MHZ + 999) / 1000;
  localparam int REA_I = (`T_REA_NS * `CLK_MHZ + 999) / 1000;
  localparam int RHIGH_I = (`T_REH_NS * `CLK_MHZ + 999) / 1000;
  localparam int WB_I = (`T_WB_NS * `CLK_MHZ + 999) / 1000;
  // Read low phase also covers access time, so sampling at its end is safe
  localparam logic [3:0] RLOW_CYC = 4'(RP_I > REA_I ? RP_I : REA_I);
  localparam logic [3:0] WLOW_CYC = 4'(WLOW_I);
  localparam logic [3:0] WHIGH_CYC = 4'(WHIGH_I);
  localparam logic [3:0] RHIGH_CYC = 4'(RHIGH_I);
  localparam logic [3:0] WB_CYC = 4'(WB_I);
  localparam logic [LEN_W-1:0] PAGE_WORDS = LEN_W'(WIDE ? `PAGE_WORDS_X16 : `PAGE_WORDS_X8);

  flash_host_pkg::host_state_t state_reg, state_next;
  flash_host_pkg::flash_op_t op_reg;
  logic [7:0] cmd1_reg, cmd2_reg, dec_cmd1, dec_cmd2;
  logic use_cmd1_reg, use_cmd2_reg, use_addr_reg, write_reg, read_reg, busy_wait_reg;
  logic dec_use_cmd1, dec_use_cmd2, dec_use_addr, dec_write, dec_read, dec_busy, dec_ready;
  logic [1:0] first_idx_reg, last_idx_reg, dec_first, dec_last, idx_reg, idx_next;
  logic [`COL_W-1:0] col_reg;
  logic [`ROW_W-1:0] row_reg;
  logic [LEN_W-1:0] remain_reg;
  logic go_reg, low_reg, hi_reg, advance, tick, tmr_load, step_done, accept, take_word;
  logic [3:0] tmr_count;
  logic rd_sample;

  pulse_timer #(.CNT_W(4)) strobe_timer (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .load_i(tmr_load),
    .count_i(tmr_count),
    .tick_o(tick)
  );

  // Operation decode into command codes and address span
  always_comb begin
    dec_cmd1 = `CMD_READ;
    dec_cmd2 = `CMD_READ_GO;
    dec_use_cmd1 = 1'b1;
    dec_use_cmd2 = 1'b0;
    dec_use_addr = 1'b1;
    dec_first = `ADDR_COL_FIRST;
    dec_last = `ADDR_ROW_LAST;
    dec_write = 1'b0;
    dec_read = 1'b0;
    dec_busy = 1'b1;
    dec_ready = 1'b1; // R27
    case (cmd_op_i)
      flash_host_pkg::OP_READ: begin
        dec_use_cmd2 = 1'b1; // R19 R9
        dec_read = 1'b1;
      end
      flash_host_pkg::OP_READ_COPY: begin
        dec_cmd2 = `CMD_COPY_READ_GO; // R16
        dec_use_cmd2 = 1'b1;
      end
      flash_host_pkg::OP_IDENTIFY: begin
        dec_cmd1 = `CMD_IDENTIFY; // R17
        dec_use_addr = 1'b0;
        dec_read = 1'b1;
        dec_busy = 1'b0;
      end
      flash_host_pkg::OP_RESET: begin
        dec_cmd1 = `CMD_RESET; // R17 R21
        dec_use_addr = 1'b0;
        dec_ready = 1'b0;
      end
      flash_host_pkg::OP_PROGRAM, flash_host_pkg::OP_CACHE_PROG: begin
        dec_cmd1 = `CMD_PROG; // R18 R9
        dec_cmd2 = (cmd_op_i == flash_host_pkg::OP_CACHE_PROG) ? `CMD_CACHE_GO : `CMD_PROG_GO; // R15
        dec_use_cmd2 = 1'b1;
        dec_write = 1'b1;
      end
      flash_host_pkg::OP_COPY_PROG: begin
        dec_cmd1 = `CMD_COPY_PROG; // R16
        dec_cmd2 = `CMD_PROG_GO;
        dec_use_cmd2 = 1'b1;
      end
      flash_host_pkg::OP_ERASE: begin
        dec_cmd1 = `CMD_ERASE; // R18
        dec_cmd2 = `CMD_ERASE_GO;
        dec_use_cmd2 = 1'b1;
        dec_first = `ADDR_ROW_FIRST; // R8 R13
      end
      flash_host_pkg::OP_RAND_IN: begin
        dec_cmd1 = `CMD_COPY_PROG; // R20
        dec_last = `ADDR_COL_LAST;
        dec_write = 1'b1;
        dec_busy = 1'b0;
      end
      flash_host_pkg::OP_RAND_OUT: begin
        dec_cmd1 = `CMD_RAND_OUT; // R20
        dec_cmd2 = `CMD_RAND_OUT_GO;
        dec_use_cmd2 = 1'b1;
        dec_last = `ADDR_COL_LAST;
        dec_read = 1'b1;
        dec_busy = 1'b0;
      end
      flash_host_pkg::OP_STATUS: begin
        dec_cmd1 = `CMD_STATUS; // R17 R21
        dec_use_addr = 1'b0;
        dec_read = 1'b1;
        dec_busy = 1'b0;
        dec_ready = 1'b0;
      end
      default: begin
        // Auto-read stream: no command, no address, just read strobes
        dec_use_cmd1 = 1'b0; // R4
        dec_use_addr = 1'b0;
        dec_read = 1'b1;
        dec_busy = 1'b0;
      end
    endcase
  end

  assign accept = (state_reg == flash_host_pkg::ST_IDLE) && cmd_valid_i;
  assign take_word = (state_reg == flash_host_pkg::ST_WFETCH) && wr_valid_i && wr_ready_o;
  assign step_done = tick && hi_reg;
  assign rd_sample = (state_reg == flash_host_pkg::ST_RDATA) && tick && low_reg;
  assign tmr_load = go_reg || (tick && low_reg);

  always_comb begin
    if (go_reg) begin
      if (state_reg == flash_host_pkg::ST_SETTLE) begin
        tmr_count = WB_CYC;
      end else if (state_reg == flash_host_pkg::ST_RDATA) begin
        tmr_count = RLOW_CYC;
      end else begin
        tmr_count = WLOW_CYC;
      end
    end else if (state_reg == flash_host_pkg::ST_RDATA) begin
      tmr_count = RHIGH_CYC;
    end else begin
      tmr_count = WHIGH_CYC;
    end
  end

  // Sequencing of bus cycles
  always_comb begin
    state_next = state_reg;
    advance = 1'b0;
    idx_next = idx_reg;
    case (state_reg)
      flash_host_pkg::ST_IDLE: begin
        if (cmd_valid_i) begin
          advance = 1'b1;
          if (dec_ready) begin
            state_next = flash_host_pkg::ST_READY;
          end else begin
            state_next = flash_host_pkg::ST_CMD1;
          end
        end
      end
      flash_host_pkg::ST_READY: begin
        if (rb_i) begin // R27 R3
          advance = 1'b1;
          state_next = use_cmd1_reg ? flash_host_pkg::ST_CMD1 : flash_host_pkg::ST_RDATA;
        end
      end
      flash_host_pkg::ST_CMD1: begin
        if (step_done) begin
          advance = 1'b1;
          idx_next = first_idx_reg;
          state_next = use_addr_reg ? flash_host_pkg::ST_ADDR : flash_host_pkg::ST_SETTLE;
        end
      end
      flash_host_pkg::ST_ADDR, flash_host_pkg::ST_WDATA: begin
        if (step_done) begin
          advance = 1'b1;
          if (state_reg == flash_host_pkg::ST_ADDR && idx_reg != last_idx_reg) begin
            idx_next = idx_reg + 2'h1; // R6
          end else if (write_reg && remain_reg != '0) begin
            state_next = flash_host_pkg::ST_WFETCH;
          end else if (use_cmd2_reg) begin
            state_next = flash_host_pkg::ST_CMD2;
          end else begin
            state_next = flash_host_pkg::ST_DONE;
          end
        end
      end
      flash_host_pkg::ST_WFETCH: begin
        if (take_word) begin
          advance = 1'b1;
          state_next = flash_host_pkg::ST_WDATA;
        end
      end
      flash_host_pkg::ST_CMD2: begin
        if (step_done) begin
          advance = 1'b1;
          state_next = flash_host_pkg::ST_SETTLE;
        end
      end
      flash_host_pkg::ST_SETTLE, flash_host_pkg::ST_BUSY: begin
        // Ready/busy is not valid until the settle time has run out
        if ((state_reg == flash_host_pkg::ST_SETTLE && tick && !go_reg) ||
            (state_reg == flash_host_pkg::ST_BUSY && rb_i)) begin
          advance = 1'b1;
          if (state_reg == flash_host_pkg::ST_SETTLE && busy_wait_reg) begin
            state_next = flash_host_pkg::ST_BUSY; // R2
          end else if (read_reg && remain_reg != '0) begin
            state_next = flash_host_pkg::ST_RDATA;
          end else begin
            state_next = flash_host_pkg::ST_DONE;
          end
        end
      end
      flash_host_pkg::ST_RDATA: begin
        if (step_done) begin
          advance = 1'b1;
          state_next = (remain_reg == '0) ? flash_host_pkg::ST_DONE : flash_host_pkg::ST_RDATA;
        end
      end
      default: begin
        advance = 1'b1;
        state_next = flash_host_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= flash_host_pkg::ST_IDLE;
      idx_reg <= `ADDR_COL_FIRST;
      go_reg <= 1'b0;
      low_reg <= 1'b0;
      hi_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      idx_reg <= idx_next;
      go_reg <= advance && (state_next inside {flash_host_pkg::ST_CMD1, flash_host_pkg::ST_ADDR,
        flash_host_pkg::ST_WDATA, flash_host_pkg::ST_CMD2, flash_host_pkg::ST_SETTLE,
        flash_host_pkg::ST_RDATA});
      if (go_reg) begin
        low_reg <= (state_reg != flash_host_pkg::ST_SETTLE);
      end else if (tick && low_reg) begin
        low_reg <= 1'b0;
      end
      if (tick && low_reg) begin
        hi_reg <= 1'b1;
      end else if (step_done) begin
        hi_reg <= 1'b0;
      end
    end
  end

  // Request latch and word counting
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      op_reg <= flash_host_pkg::OP_RESET;
      cmd1_reg <= `CMD_RESET;
      cmd2_reg <= `CMD_READ_GO;
      {use_cmd1_reg, use_cmd2_reg, use_addr_reg} <= 3'h0;
      {write_reg, read_reg, busy_wait_reg} <= 3'h0;
      first_idx_reg <= `ADDR_COL_FIRST;
      last_idx_reg <= `ADDR_ROW_LAST;
      col_reg <= '0;
      row_reg <= '0;
      remain_reg <= '0;
    end else if (accept) begin
      op_reg <= cmd_op_i;
      cmd1_reg <= dec_cmd1;
      cmd2_reg <= dec_cmd2;
      {use_cmd1_reg, use_cmd2_reg, use_addr_reg} <= {dec_use_cmd1, dec_use_cmd2, dec_use_addr};
      {write_reg, read_reg, busy_wait_reg} <= {dec_write, dec_read, dec_busy};
      first_idx_reg <= dec_first;
      last_idx_reg <= dec_last;
      // Word-wide column has one bit less; the top bit goes out low
      col_reg <= WIDE ? {1'b0, col_addr_i[`COL_W-2:0]} : col_addr_i; // R5 R11
      row_reg <= row_addr_i; // R12
      remain_reg <= (len_i > PAGE_WORDS) ? PAGE_WORDS : len_i; // R14
    end else if (take_word || rd_sample) begin
      remain_reg <= remain_reg - 1'b1;
    end
  end

  // Pin drive: setup values change one cycle before the strobe falls
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ce_n_o <= 1'b1;
      cle_o <= 1'b0;
      ale_o <= 1'b0;
      io_o <= '0;
      io_oe_o <= 1'b0;
    end else if (advance) begin
      ce_n_o <= (state_next == flash_host_pkg::ST_IDLE); // R10
      cle_o <= (state_next inside {flash_host_pkg::ST_CMD1, flash_host_pkg::ST_CMD2}); // R24
      ale_o <= (state_next == flash_host_pkg::ST_ADDR); // R25
      io_oe_o <= (state_next inside {flash_host_pkg::ST_CMD1, flash_host_pkg::ST_ADDR,
        flash_host_pkg::ST_WDATA, flash_host_pkg::ST_CMD2});
      case (state_next)
        // Straight from idle the latched code is still the old one
        flash_host_pkg::ST_CMD1: io_o <= IO_W'(accept ? dec_cmd1 : cmd1_reg); // R23
        flash_host_pkg::ST_CMD2: io_o <= IO_W'(cmd2_reg);
        flash_host_pkg::ST_WDATA: io_o <= wr_data_i;
        flash_host_pkg::ST_ADDR: begin
          case (idx_next) // R5 R23
            `ADDR_COL_FIRST: io_o <= IO_W'(col_reg[7:0]);
            `ADDR_COL_LAST: io_o <= IO_W'(col_reg[`COL_W-1:8]);
            `ADDR_ROW_FIRST: io_o <= IO_W'(row_reg[7:0]);
            default: io_o <= IO_W'(row_reg[`ROW_W-1:8]);
          endcase
        end
        default: io_o <= io_o;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      we_n_o <= 1'b1;
      read_strobe_n_o <= 1'b1;
    end else if (go_reg && state_reg != flash_host_pkg::ST_SETTLE) begin
      we_n_o <= (state_reg == flash_host_pkg::ST_RDATA); // R10
      read_strobe_n_o <= (state_reg != flash_host_pkg::ST_RDATA); // R26
    end else if (tick && low_reg) begin
      we_n_o <= 1'b1;
      read_strobe_n_o <= 1'b1;
    end
  end

  // Held protected from reset until software releases it
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wp_n_o <= 1'b0;
    end else begin
      wp_n_o <= wp_release_i; // R1
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_valid_o <= 1'b0;
      rd_data_o <= '0;
      wr_ready_o <= 1'b0;
      done_o <= 1'b0;
      cmd_busy_o <= 1'b0;
    end else begin
      rd_valid_o <= rd_sample;
      if (rd_sample) begin
        rd_data_o <= io_i; // R26
      end
      wr_ready_o <= (state_next == flash_host_pkg::ST_WFETCH);
      done_o <= (state_reg == flash_host_pkg::ST_DONE);
      cmd_busy_o <= (state_next != flash_host_pkg::ST_IDLE);
    end
  end

  a_strobe_select: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !we_n_o |-> !ce_n_o && io_oe_o && !(cle_o && ale_o)) // R10
    else $error("write strobe without select or drive");
  a_read_release: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !read_strobe_n_o |-> !io_oe_o && we_n_o && !ce_n_o) // R26
    else $error("read strobe while bus driven");
  a_upper_low: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (cle_o || ale_o) && !we_n_o |-> (io_o >> 8) == '0) // R23
    else $error("upper lines not low in command or address cycle");
  a_ready_gate: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    state_reg == flash_host_pkg::ST_READY && !rb_i |=> state_reg == flash_host_pkg::ST_READY) // R27
    else $error("left ready wait while device busy");
  a_addr_order: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    state_reg == flash_host_pkg::ST_ADDR && step_done && idx_reg != last_idx_reg
    |=> idx_reg == $past(idx_reg) + 2'h1 && ale_o && go_reg) // R6
    else $error("address cycles out of order");
  a_erase_rows: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    op_reg == flash_host_pkg::OP_ERASE && ale_o && !we_n_o |-> idx_reg[1]) // R8
    else $error("erase sent a column cycle");
  a_col_pad: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    ale_o && !we_n_o && idx_reg == `ADDR_COL_LAST |-> io_o[7:4] == 4'h0) // R5
    else $error("column high cycle not padded low");
  a_read_confirm: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    op_reg == flash_host_pkg::OP_READ && state_reg == flash_host_pkg::ST_CMD2 && !we_n_o
    |-> io_o[7:0] == `CMD_READ_GO && $past(idx_reg) == `ADDR_ROW_LAST) // R19
    else $error("page read confirm wrong");
  a_prog_confirm: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    op_reg == flash_host_pkg::OP_PROGRAM && cle_o && !we_n_o
    |-> io_o[7:0] == `CMD_PROG || io_o[7:0] == `CMD_PROG_GO) // R18
    else $error("program codes wrong");
  a_code_legal: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    cle_o && !we_n_o |-> io_o[7:0] inside {`CMD_READ, `CMD_READ_GO, `CMD_COPY_READ_GO,
      `CMD_IDENTIFY, `CMD_RESET, `CMD_PROG, `CMD_PROG_GO, `CMD_CACHE_GO, `CMD_COPY_PROG,
      `CMD_ERASE, `CMD_ERASE_GO, `CMD_RAND_OUT, `CMD_RAND_OUT_GO, `CMD_STATUS}) // R22
    else $error("undefined command code driven");
  a_busy_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    state_reg == flash_host_pkg::ST_SETTLE && go_reg |-> !advance [*2]) // R2
    else $error("settle time cut short");

  c_page_read: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    op_reg == flash_host_pkg::OP_READ && rd_valid_o ##1 done_o);
  c_program: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    op_reg == flash_host_pkg::OP_PROGRAM && done_o);
  c_erase: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    op_reg == flash_host_pkg::OP_ERASE && state_reg == flash_host_pkg::ST_BUSY ##[1:50] done_o);
  c_stall: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    wr_ready_o && !wr_valid_i ##1 take_word);

endmodule : page_flash_host

// ===== logic/flash_host_params.svh
// Command codes, address cycle layout, page geometry and strobe timing
`ifndef FLASH_HOST_PARAMS_SVH
`define FLASH_HOST_PARAMS_SVH

`define CLK_MHZ 20
`define T_WP_NS 25
`define T_WH_NS 15
`define T_RP_NS 25
`define T_REH_NS 15
`define T_REA_NS 30
`define T_WB_NS 100

`define CMD_READ 8'h00
`define CMD_READ_GO 8'h30
`define CMD_COPY_READ_GO 8'h35
`define CMD_IDENTIFY 8'h90
`define CMD_RESET 8'hFF
`define CMD_PROG 8'h80
`define CMD_PROG_GO 8'h10
`define CMD_CACHE_GO 8'h15
`define CMD_COPY_PROG 8'h85
`define CMD_ERASE 8'h60
`define CMD_ERASE_GO 8'hD0
`define CMD_RAND_OUT 8'h05
`define CMD_RAND_OUT_GO 8'hE0
`define CMD_STATUS 8'h70

`define ADDR_COL_FIRST 2'h0
`define ADDR_COL_LAST 2'h1
`define ADDR_ROW_FIRST 2'h2
`define ADDR_ROW_LAST 2'h3

`define COL_W 12
`define ROW_W 16
`define PAGE_WORDS_X8 12'h840
`define PAGE_WORDS_X16 12'h420

`endif

// ===== logic/flash_host_pkg.sv
// Types shared by the flash host controller
package flash_host_pkg;

  typedef enum logic [3:0] {
    OP_READ,
    OP_READ_COPY,
    OP_IDENTIFY,
    OP_RESET,
    OP_PROGRAM,
    OP_CACHE_PROG,
    OP_COPY_PROG,
    OP_ERASE,
    OP_RAND_IN,
    OP_RAND_OUT,
    OP_STATUS,
    OP_STREAM
  } flash_op_t;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_READY,
    ST_CMD1,
    ST_ADDR,
    ST_WFETCH,
    ST_WDATA,
    ST_CMD2,
    ST_SETTLE,
    ST_BUSY,
    ST_RDATA,
    ST_DONE
  } host_state_t;

endpackage : flash_host_pkg

// ===== logic/pulse_timer.sv
// Down counter giving a one-cycle tick a loaded number of cycles later
module pulse_timer #(
  parameter int CNT_W = 4
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic load_i,
  input wire logic [CNT_W-1:0] count_i,
  output logic tick_o
);

  logic [CNT_W-1:0] cnt_reg;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_reg <= '0;
    end else if (load_i) begin
      cnt_reg <= count_i;
    end else if (cnt_reg != '0) begin
      cnt_reg <= cnt_reg - 1'b1;
    end
  end

  // Tick must not look at load_i: the caller reloads on the tick itself
  assign tick_o = (cnt_reg == CNT_W'(1));

endmodule : pulse_timer

// ===== sim/flash_dev_model.sv
// Behavioural page flash device answering the host strobes
module flash_dev_model #(
  parameter bit AUTO_READ = 1'b1,
  parameter logic [7:0] ID0 = 8'h5A,
  parameter logic [7:0] ID1 = 8'hC3
) (
  input wire logic ce_n_i,
  input wire logic cle_i,
  input wire logic ale_i,
  input wire logic we_n_i,
  input wire logic read_strobe_n_i,
  input wire logic wp_n_i,
  input wire logic [7:0] io_i,
  input wire logic [15:0] busy_ns_i,
  output logic rb_low_o,
  output logic [7:0] io_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cmd, val;
  logic [7:0] dreg [16];
  logic [7:0] abyte [4];
  logic [11:0] col;
  logic [1:0] mode;
  logic drv, idx;
  int acyc, k, progs, erases;

  initial begin
    {cmd, val, col, mode, drv, idx, rb_low_o} = '0;
    {acyc, k, progs, erases} = '0;
    abyte = '{default: 8'h00};
    for (int i = 0; i < 16; i++) dreg[i] = AUTO_READ ? {4'h3, i[3:0]} : 8'h00;
  end

  // Pin is only pulled low, never driven high, whatever the chip select does
  task automatic go_busy();
    rb_low_o = 1'b1;
    #(busy_ns_i) rb_low_o = 1'b0;
  endtask : go_busy

  always @(posedge we_n_i) begin
    if (!ce_n_i && cle_i && (!rb_low_o || io_i inside {8'hFF, 8'h70})) begin
      cmd = io_i;
      // Confirm codes keep the address count of their setup code
      if (!(io_i inside {8'h30, 8'h35, 8'h10, 8'h15, 8'hD0, 8'hE0})) acyc = 0;
      mode = io_i == 8'h70 ? 2'd1 : io_i == 8'h90 ? 2'd2 : 2'd0;
      idx = 1'b0;
      if (io_i inside {8'h30, 8'h35}) begin
        for (int i = 0; i < 16; i++) dreg[i] = {4'h3, i[3:0]} ^ abyte[2];
      end
      if (wp_n_i && io_i inside {8'h10, 8'h15}) progs++;
      if (wp_n_i && io_i == 8'hD0) erases++;
      if (io_i inside {8'h30, 8'h35, 8'h10, 8'h15, 8'hD0, 8'hFF}) fork
        go_busy();
      join_none
    end else if (!ce_n_i && ale_i) begin
      k = acyc + (cmd == 8'h60 ? 2 : 0);
      if (k < 4) abyte[k] = io_i;
      acyc++;
      col = {abyte[1][3:0], abyte[0]};
    end else if (!ce_n_i && !cle_i && cmd inside {8'h80, 8'h85}) begin
      dreg[col[3:0]] = io_i;
      col++;
    end
  end

  always @(negedge read_strobe_n_i) begin
    if (!ce_n_i) begin
      val = mode == 2'd1 ? {wp_n_i, !rb_low_o, 6'h00} : mode == 2'd2 ? (idx ? ID1 : ID0)
          : dreg[col[3:0]];
      idx = 1'b1;
      col++;
      drv = 1'b1;
    end
  end

  // Released bus shows the inverse so a stale value never passes
  always @(posedge read_strobe_n_i) drv = 1'b0;
  assign io_o = drv ? val : ~val;
endmodule : flash_dev_model

// ===== sim/tb.sv
// Bench for the page flash host against the behavioural device
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] ID_A = 8'h5A;  // Arbitrary
  localparam logic [7:0] ID_B = 8'hC3;  // Arbitrary
  logic ref_clk_i = 1'b0, rst_n_i = 1'b0, cmd_valid_i = 1'b0, wr_valid_i = 1'b0;
  logic wp_release_i = 1'b0, took = 1'b0;
  flash_host_pkg::flash_op_t cmd_op_i = flash_host_pkg::OP_STATUS;
  logic [11:0] col = '0, len = '0, c;
  logic [15:0] row = '0, busy_ns = 16'd400, r;
  logic [7:0] wr_data_i = '0, rd_data, host_io, dev_io, w0, w1, w2;
  logic cmd_busy, done, wr_ready, rd_valid, ce_n, cle, ale, we_n, rs_n, wp_n, io_oe, rb_low;
  logic [7:0] exp_q[$], wq[$];
  int mismatches = 0, num_checks = 0, e;
  wire logic [7:0] bus = io_oe ? host_io : dev_io;
  wire logic rb = rb_low ? 1'b0 : 1'b1;
  flash_host_pkg::flash_op_t ops[4] = '{flash_host_pkg::OP_READ_COPY,
      flash_host_pkg::OP_COPY_PROG, flash_host_pkg::OP_CACHE_PROG, flash_host_pkg::OP_RESET};
  logic [7:0] codes[4] = '{8'h35, 8'h10, 8'h15, 8'hFF};

  page_flash_host #(.WIDE(1'b0), .LEN_W(12)) DUT (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .cmd_valid_i(cmd_valid_i), .cmd_op_i(cmd_op_i), .col_addr_i(col), .row_addr_i(row),
    .len_i(len), .wr_valid_i(wr_valid_i), .wr_data_i(wr_data_i), .wp_release_i(wp_release_i),
    .rb_i(rb), .io_i(bus), .cmd_busy_o(cmd_busy), .done_o(done), .wr_ready_o(wr_ready),
    .rd_valid_o(rd_valid), .rd_data_o(rd_data), .ce_n_o(ce_n), .cle_o(cle), .ale_o(ale),
    .we_n_o(we_n), .read_strobe_n_o(rs_n), .wp_n_o(wp_n), .io_o(host_io), .io_oe_o(io_oe));
  flash_dev_model #(.AUTO_READ(1'b1), .ID0(ID_A), .ID1(ID_B)) flash (.ce_n_i(ce_n),
    .cle_i(cle), .ale_i(ale), .we_n_i(we_n), .read_strobe_n_i(rs_n), .wp_n_i(wp_n),
    .io_i(bus), .busy_ns_i(busy_ns), .rb_low_o(rb_low), .io_o(dev_io));

  always #25 ref_clk_i = ~ref_clk_i;

  task automatic chk(logic [7:0] got, logic [7:0] exp, string what);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize

  task automatic run(flash_host_pkg::flash_op_t op, logic [11:0] ca, logic [15:0] ra,
                     logic [11:0] n, string name);
    int t;
    t = 0;
    @(negedge ref_clk_i);
    cmd_op_i = op;
    col = ca;
    row = ra;
    len = n;
    cmd_valid_i = 1'b1;
    do @(negedge ref_clk_i); while (cmd_busy !== 1'b1 && ++t < 20);
    cmd_valid_i = 1'b0;
    while (done !== 1'b1 && ++t < 5000) @(negedge ref_clk_i);
    @(negedge ref_clk_i);
    chk(8'(t >= 5000), 8'h00, "no completion");
    chk(8'(exp_q.size()), 8'h00, "words missing");
    $display("test %s done", name);
  endtask : run

  // Oldest expected word against each delivered word
  always @(negedge ref_clk_i) begin
    if (rd_valid === 1'b1 && exp_q.size() > 0) chk(rd_data, exp_q.pop_front(), "word");
    else if (rd_valid === 1'b1) chk(8'h01, 8'h00, "extra word");
  end

  // Word is consumed at the edge after ready and valid were both seen
  always @(negedge ref_clk_i) begin
    if (took) void'(wq.pop_front());
    wr_valid_i <= wq.size() > 0;
    wr_data_i <= wq.size() > 0 ? wq[0] : 8'h00;
    took = wr_ready === 1'b1 && wq.size() > 0;
  end

  initial begin
    #3000000;
    mismatches++;
    summarize();
  end

  initial begin
    void'($urandom(32'hdff5924f));
    repeat (5) @(negedge ref_clk_i);
    rst_n_i = 1'b1;
    for (int i = 0; i < 2; i++) exp_q.push_back({4'h3, i[3:0]});
    run(flash_host_pkg::OP_STREAM, 12'h000, 16'h0000, 12'd2, "auto read");
    exp_q.push_back(8'h40);
    run(flash_host_pkg::OP_STATUS, 12'h000, 16'h0000, 12'd1, "status guarded");
    wp_release_i = 1'b1;
    exp_q.push_back(8'hC0);
    run(flash_host_pkg::OP_STATUS, 12'h000, 16'h0000, 12'd1, "status open");
    c = 12'($urandom_range(2111));
    r = 16'($urandom);
    busy_ns = 16'($urandom_range(2000, 100));
    for (int i = 0; i < 3; i++) exp_q.push_back({4'h3, c[3:0] + 4'(i)} ^ r[7:0]);
    run(flash_host_pkg::OP_READ, c, r, 12'd3, "page read");
    chk(flash.abyte[0], c[7:0], "addr 1");
    chk(flash.abyte[1], {4'h0, c[11:8]}, "addr 2");
    chk(flash.abyte[2], r[7:0], "addr 3");
    chk(flash.abyte[3], r[15:8], "addr 4");
    chk(8'(flash.acyc), 8'd4, "addr count");
    {w0, w1, w2} = 24'($urandom);
    e = flash.progs;
    wq.push_back(w0);
    wq.push_back(w1);
    run(flash_host_pkg::OP_PROGRAM, c, r, 12'd2, "program");
    chk(8'(flash.progs - e), 8'd1, "program count");
    wq.push_back(w2);
    run(flash_host_pkg::OP_RAND_IN, c + 12'd1, r, 12'd1, "random in");
    exp_q.push_back(w0);
    exp_q.push_back(w2);
    run(flash_host_pkg::OP_RAND_OUT, c, r, 12'd2, "random out");
    r = 16'($urandom);
    e = flash.erases;
    for (int i = 0; i < 2; i++) begin
      wp_release_i = i[0];
      run(flash_host_pkg::OP_ERASE, 12'h000, r, 12'd0, "erase");
      chk(8'(flash.erases - e), 8'(i), "erase count");
      chk(8'(flash.acyc), 8'd2, "erase addr count");
      chk(flash.abyte[3], r[15:8], "erase row");
    end
    exp_q.push_back(ID_A);
    exp_q.push_back(ID_B);
    run(flash_host_pkg::OP_IDENTIFY, 12'h000, 16'h0000, 12'd2, "identify");
    for (int i = 0; i < 4; i++) begin
      if (i == 2) wq.push_back(w1);
      run(ops[i], c, r, 12'(i == 2), "command table");
      chk(flash.cmd, codes[i], "last command");
    end
    summarize();
  end
endmodule : tb
